// file: core/msa_checker.sv
// memory attribute and security attribution checker, top level
//----------------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------------
// Notes on behaviour
// - data placed little-endian: lowest address takes the lowest lane
// - byte, halfword and word accesses; floating operands use these
// - normal regions may be reordered, cached, read speculatively
// - device accesses keep program order among device accesses
// - device regions are always shareable and never cacheable
// - fetch from no-execute region is blocked with a manage fault
// - only strict-order and early-ack device attribute pairs accepted
// - never merge accesses; ordering operations wait for device traffic
// - fixed default memory map covers the full 4GB space
// - attribution table plus fixed source classify every address
// - classification depends on the address only, not the state
// - transaction security tag follows the address classification
// - non-secure access to a secure address is blocked and faults
// - gateway instruction only valid in callable gateway memory
// - secure access to non-secure address goes out marked non-secure
// - separate secure and non-secure protection banks, picked by class
// - eight regions per protection bank and in the attribution table
`timescale 1ns/1ps
`include "msa_regs.svh"
module msa_checker #(
    parameter int N  = 8,
    parameter int IW = 3
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // core side request
    input  wire logic                  req_valid_i,
    output logic                       req_ready_o,
    input  wire logic [31:0]           req_addr_i,
    input  wire logic [1:0]            req_size_i,
    input  wire logic                  req_write_i,
    input  wire logic                  req_fetch_i,
    input  wire logic                  req_gateway_i,
    input  wire logic                  req_barrier_i,
    input  wire logic                  req_nonsec_i,
    input  wire logic [31:0]           req_wdata_i,
    // attribution table
    input  wire logic                  sau_enable_i,
    input  wire logic [N-1:0][26:0]    sau_base_i,
    input  wire logic [N-1:0][26:0]    sau_limit_i,
    input  wire logic [N-1:0]          sau_en_i,
    input  wire logic [N-1:0]          sau_nsc_i,
    // secure protection bank
    input  wire logic                  mpus_enable_i,
    input  wire logic [N-1:0][26:0]    mpus_base_i,
    input  wire logic [N-1:0][26:0]    mpus_limit_i,
    input  wire logic [N-1:0]          mpus_en_i,
    input  wire logic [N-1:0]          mpus_xn_i,
    input  wire logic [N-1:0]          mpus_ro_i,
    input  msa_pkg::msa_memattr_t      mpus_attr_i [N],
    // non-secure protection bank
    input  wire logic                  mpun_enable_i,
    input  wire logic [N-1:0][26:0]    mpun_base_i,
    input  wire logic [N-1:0][26:0]    mpun_limit_i,
    input  wire logic [N-1:0]          mpun_en_i,
    input  wire logic [N-1:0]          mpun_xn_i,
    input  wire logic [N-1:0]          mpun_ro_i,
    input  msa_pkg::msa_memattr_t      mpun_attr_i [N],
    // system bus side
    output logic                       bus_valid_o,
    input  wire logic                  bus_ready_i,
    input  wire logic                  bus_done_i,
    output logic [31:0]                bus_addr_o,
    output logic                       bus_write_o,
    output logic                       bus_fetch_o,
    output logic                       bus_nonsec_o,
    output logic                       bus_device_o,
    output logic                       bus_shareable_o,
    output logic                       bus_cacheable_o,
    output logic                       bus_early_ack_o,
    output logic [3:0]                 bus_byte_en_o,
    output logic [31:0]                bus_wdata_o,
    // fault and status pulses
    output logic                       fault_mem_manage_o,
    output logic                       fault_secure_o,
    output logic                       fault_align_o,
    output logic                       gateway_ok_o
);
    import msa_pkg::*;

    msa_state_t   state_reg;
    logic         dev_busy_reg;
    logic         sau_hit;
    logic [IW-1:0] sau_idx;
    logic         addr_ns;
    logic         addr_nsc;
    logic         fixed_attribution_source_ns;
    logic         mpu_on;
    logic         mpu_hit;
    logic [IW-1:0] mpu_idx;
    logic [N-1:0][26:0] mpu_base;
    logic [N-1:0][26:0] mpu_limit;
    logic [N-1:0] mpu_en;
    logic         dflt_dev;
    logic         rg_xn;
    logic         rg_ro;
    msa_memattr_t rg_attr;
    logic         req_dev;
    logic         sec_fault;
    logic         mm_fault;
    logic         al_fault;
    logic         gw_ok;
    logic         accept;
    logic [3:0]   be_next;

    //------------------------------------------------------------------
    // security classification
    //------------------------------------------------------------------
    msa_region_match #(
        .N  (N),
        .IW (IW)
    ) u_sau_match (
        .addr_i  (req_addr_i),
        .base_i  (sau_base_i),
        .limit_i (sau_limit_i),
        .en_i    (sau_en_i),
        .hit_o   (sau_hit),
        .idx_o   (sau_idx)
    );

    // address alone decides; req_nonsec_i is not an input here
    assign fixed_attribution_source_ns = req_addr_i[`MSA_FIXED_ATTRIBUTION_SOURCE_NS_BIT];
    always_comb begin
        addr_ns  = 1'b0;
        addr_nsc = 1'b0;
        // non-secure only if both sources say so; callable comes from the table alone
        if (sau_enable_i && sau_hit) begin
            addr_ns  = fixed_attribution_source_ns && !sau_nsc_i[sau_idx];
            addr_nsc = sau_nsc_i[sau_idx];
        end
    end

    //------------------------------------------------------------------
    // protection bank select and lookup
    //------------------------------------------------------------------
    // bank chosen by the address class, not by the core state
    always_comb begin
        if (addr_ns) begin
            mpu_on    = mpun_enable_i;
            mpu_base  = mpun_base_i;
            mpu_limit = mpun_limit_i;
            mpu_en    = mpun_en_i;
        end else begin
            mpu_on    = mpus_enable_i;
            mpu_base  = mpus_base_i;
            mpu_limit = mpus_limit_i;
            mpu_en    = mpus_en_i;
        end
    end

    msa_region_match #(
        .N  (N),
        .IW (IW)
    ) u_mpu_match (
        .addr_i  (req_addr_i),
        .base_i  (mpu_base),
        .limit_i (mpu_limit),
        .en_i    (mpu_en),
        .hit_o   (mpu_hit),
        .idx_o   (mpu_idx)
    );

    // default map: peripheral and everything from external devices up
    assign dflt_dev = (req_addr_i >= `MSA_PERIPH_BASE
                       && req_addr_i <= `MSA_PERIPH_END)
                      || req_addr_i >= `MSA_EXTDEV_BASE;

    always_comb begin
        rg_xn   = dflt_dev;
        rg_ro   = 1'b0;
        rg_attr = dflt_dev ? MSA_DEV_EARLY : MSA_NORMAL;
        if (mpu_on && mpu_hit) begin
            if (addr_ns) begin
                rg_xn   = mpun_xn_i[mpu_idx];
                rg_ro   = mpun_ro_i[mpu_idx];
                rg_attr = mpun_attr_i[mpu_idx];
            end else begin
                rg_xn   = mpus_xn_i[mpu_idx];
                rg_ro   = mpus_ro_i[mpu_idx];
                rg_attr = mpus_attr_i[mpu_idx];
            end
        end
    end

    assign req_dev = rg_attr != MSA_NORMAL;

    //------------------------------------------------------------------
    // fault decisions
    //------------------------------------------------------------------
    assign gw_ok = req_nonsec_i && req_fetch_i && req_gateway_i
                   && addr_nsc;
    assign sec_fault = req_nonsec_i && !addr_ns && !gw_ok;

    // unaligned accesses are not supported on this path
    always_comb begin
        al_fault = 1'b0;
        be_next  = `MSA_BE_NONE;
        unique case (req_size_i)
            `MSA_SIZE_BYTE: be_next = `MSA_BE_BYTE << req_addr_i[1:0];
            `MSA_SIZE_HALF: begin
                be_next  = `MSA_BE_HALF << req_addr_i[1:0];
                al_fault = req_addr_i[0];
            end
            `MSA_SIZE_WORD: begin
                be_next  = `MSA_BE_WORD;
                al_fault = req_addr_i[1:0] != 2'h0;
            end
            default: al_fault = 1'b1;
        endcase
    end

    assign mm_fault = !sec_fault && ((req_fetch_i && rg_xn)
                      || (req_write_i && rg_ro)
                      || rg_attr == MSA_DEV_BAD);

    //------------------------------------------------------------------
    // request acceptance and ordering
    //------------------------------------------------------------------
    // one access in flight; a device access or an ordering operation
    // waits until the previous device access has completed
    assign req_ready_o = state_reg == MSA_ST_IDLE
                         && !(dev_busy_reg
                              && (req_dev || req_barrier_i));
    assign accept = req_valid_i && req_ready_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= MSA_ST_IDLE;
        end else begin
            unique case (state_reg)
                MSA_ST_IDLE: begin
                    if (accept && !req_barrier_i && !sec_fault
                        && !mm_fault && !al_fault) begin
                        state_reg <= MSA_ST_ISSUE;
                    end
                end
                MSA_ST_ISSUE: begin
                    if (bus_ready_i) begin
                        state_reg <= MSA_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // set wins over done; only one device access can be open
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dev_busy_reg <= 1'b0;
        end else if (bus_valid_o && bus_ready_i && bus_device_o) begin
            dev_busy_reg <= 1'b1;
        end else if (bus_done_i) begin
            dev_busy_reg <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // bus transaction registers
    //------------------------------------------------------------------
    assign bus_valid_o = state_reg == MSA_ST_ISSUE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_addr_o      <= '0;
            bus_write_o     <= 1'b0;
            bus_fetch_o     <= 1'b0;
            bus_nonsec_o    <= 1'b0;
            bus_device_o    <= 1'b0;
            bus_shareable_o <= 1'b0;
            bus_cacheable_o <= 1'b0;
            bus_early_ack_o <= 1'b0;
            bus_byte_en_o   <= `MSA_BE_NONE;
            bus_wdata_o     <= '0;
        end else if (accept && !req_barrier_i) begin
            bus_addr_o      <= req_addr_i;
            bus_write_o     <= req_write_i;
            bus_fetch_o     <= req_fetch_i;
            // tag follows the address even for secure software
            bus_nonsec_o    <= addr_ns;
            bus_device_o    <= req_dev;
            bus_shareable_o <= req_dev;
            // normal memory may be cached and read ahead
            bus_cacheable_o <= !req_dev;
            bus_early_ack_o <= rg_attr == MSA_DEV_EARLY;
            bus_byte_en_o   <= be_next;
            bus_wdata_o     <= req_wdata_i << {req_addr_i[1:0], 3'h0};
        end
    end

    //------------------------------------------------------------------
    // fault pulses
    //------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_secure_o     <= 1'b0;
            fault_mem_manage_o <= 1'b0;
            fault_align_o      <= 1'b0;
            gateway_ok_o       <= 1'b0;
        end else begin
            fault_secure_o     <= accept && !req_barrier_i
                                  && sec_fault;
            fault_mem_manage_o <= accept && !req_barrier_i
                                  && mm_fault;
            fault_align_o      <= accept && !req_barrier_i
                                  && !sec_fault && al_fault;
            gateway_ok_o       <= accept && !req_barrier_i
                                  && gw_ok;
        end
    end

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_fault_no_issue: assert property (
        accept && (sec_fault || mm_fault || al_fault) |=> !bus_valid_o)
        else $error("faulted access reached the bus");

    a_secure_block: assert property (
        accept && !req_barrier_i && req_nonsec_i && !addr_ns && !gw_ok
        |=> fault_secure_o && !bus_valid_o)
        else $error("non-secure access to secure address not blocked");

    a_xn_fetch: assert property (
        accept && !req_barrier_i && req_fetch_i && rg_xn && !sec_fault
        |=> fault_mem_manage_o)
        else $error("fetch from no-execute region not faulted");

    a_dev_share: assert property (
        bus_valid_o && bus_device_o |-> bus_shareable_o && !bus_cacheable_o)
        else $error("device access cacheable or not shareable");

    a_ns_tag: assert property (
        accept && !req_barrier_i && !sec_fault && !mm_fault && !al_fault
        |=> bus_valid_o && bus_nonsec_o == $past(addr_ns))
        else $error("security tag does not follow address");

    a_dev_order: assert property (
        dev_busy_reg && (req_dev || req_barrier_i) |-> !req_ready_o)
        else $error("device access overtook an open device access");

    a_dev_single: assert property (
        bus_valid_o && bus_device_o |-> !dev_busy_reg)
        else $error("second device access issued while one is open");

    a_gateway_nsc: assert property (
        gateway_ok_o |-> $past(addr_nsc) && $past(req_gateway_i))
        else $error("gateway accepted outside callable region");

    a_byte_lane: assert property (
        accept && !req_barrier_i && req_size_i == `MSA_SIZE_BYTE
        |=> bus_byte_en_o == (`MSA_BE_BYTE << $past(req_addr_i[1:0])))
        else $error("byte lane not little-endian");

    a_early_dev: assert property (
        bus_valid_o && bus_early_ack_o |-> bus_device_o)
        else $error("early ack on non-device access");

    a_bus_hold: assert property (
        bus_valid_o && !bus_ready_i |=> bus_valid_o && $stable(bus_addr_o))
        else $error("bus request dropped before acceptance");

endmodule

// file: core/msa_regs.svh
// constants of the memory security attribution checker
`ifndef MSA_REGS_SVH
`define MSA_REGS_SVH

// default memory map boundaries
`define MSA_PERIPH_BASE 32'h4000_0000
`define MSA_PERIPH_END  32'h5FFF_FFFF
`define MSA_EXTDEV_BASE 32'hA000_0000

// fixed attribution source: this address bit set means non-secure
`define MSA_FIXED_ATTRIBUTION_SOURCE_NS_BIT 28

// region granule: base/limit hold address bits [31:5]
`define MSA_GRAN_LSB    5

// access size codes
`define MSA_SIZE_BYTE   2'h0
`define MSA_SIZE_HALF   2'h1
`define MSA_SIZE_WORD   2'h2

// byte lane patterns
`define MSA_BE_BYTE     4'h1
`define MSA_BE_HALF     4'h3
`define MSA_BE_WORD     4'hF
`define MSA_BE_NONE     4'h0

`endif

// file: core/msa_pkg.sv
// types of the memory security attribution checker
package msa_pkg;

    // memory attribute per protection region
    typedef enum logic [1:0] {
        MSA_NORMAL     = 2'h0,
        MSA_DEV_STRICT = 2'h1,
        MSA_DEV_EARLY  = 2'h2,
        MSA_DEV_BAD    = 2'h3
    } msa_memattr_t;

    // issue stage states, one-hot
    typedef enum logic [1:0] {
        MSA_ST_IDLE  = 2'b01,
        MSA_ST_ISSUE = 2'b10
    } msa_state_t;

endpackage

// file: core/msa_region_match.sv
// address-range match over a table of regions
`timescale 1ns/1ps
`include "msa_regs.svh"
module msa_region_match #(
    parameter int N  = 8,
    parameter int IW = 3
) (
    input  wire logic [31:0]         addr_i,
    input  wire logic [N-1:0][26:0]  base_i,
    input  wire logic [N-1:0][26:0]  limit_i,
    input  wire logic [N-1:0]        en_i,
    output logic                     hit_o,
    output logic [IW-1:0]            idx_o
);
    logic [N-1:0] hit;
    logic [26:0]  granule;

    assign granule = addr_i[31:`MSA_GRAN_LSB];

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_rgn
            assign hit[g] = en_i[g] && granule >= base_i[g]
                            && granule <= limit_i[g];
        end
    endgenerate

    // overlapping regions: highest number wins
    always_comb begin
        hit_o = 1'b0;
        idx_o = '0;
        for (int i = 0; i < N; i++) begin
            if (hit[i]) begin
                hit_o = 1'b1;
                idx_o = IW'(i);
            end
        end
    end
endmodule

// file: dv/msa_bus_responder.sv
// bus side responder model for the attribution checker bench
`timescale 1ns/1ps
module msa_bus_responder (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic bus_valid_i,
    input  wire logic bus_device_i,
    input  wire logic slow_i,
    output logic      bus_ready_o,
    output logic      bus_done_o
);
    logic [2:0] wait_reg;
    logic [2:0] done_cnt_reg;

    // accept at once or after three stalled cycles; ready is one pulse
    always_ff @(posedge clk_i) begin
        if (rst_i || !bus_valid_i || bus_ready_o) begin
            wait_reg    <= 3'h0;
            bus_ready_o <= 1'b0;
        end else begin
            wait_reg    <= wait_reg + 3'h1;
            bus_ready_o <= !slow_i || (wait_reg == 3'h3);
        end
    end

    // device completion lags acceptance so an open txn is visible
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_cnt_reg <= 3'h0;
        end else if (bus_valid_i && bus_ready_o && bus_device_i) begin
            done_cnt_reg <= 3'h4;
        end else if (done_cnt_reg != 3'h0) begin
            done_cnt_reg <= done_cnt_reg - 3'h1;
        end
    end

    assign bus_done_o = (done_cnt_reg == 3'h1);
endmodule

// file: dv/msa_checker_test.sv
// self-checking bench of the memory security attribution checker
`timescale 1ns/1ps
module msa_checker_test;
    import msa_pkg::*;
    localparam int          N  = 8;
    localparam logic [31:0] WD = 32'h8765_43A5;
    // request control: {write, fetch, gateway, nonsec, barrier}
    localparam logic [4:0]  CW = 5'h10;
    localparam logic [4:0]  CF = 5'h08;
    localparam logic [4:0]  CG = 5'h0C;
    localparam logic [4:0]  CN = 5'h02;
    localparam logic [4:0]  CB = 5'h01;
    logic clk_i, rst_i, req_valid_i, req_ready_o, req_write_i, req_fetch_i;
    logic req_gateway_i, req_barrier_i, req_nonsec_i, sau_enable_i, slow;
    logic mpus_enable_i, mpun_enable_i, bus_valid_o, bus_ready_i, bus_done_i;
    logic bus_write_o, bus_fetch_o, bus_nonsec_o, bus_device_o, first_ready;
    logic bus_shareable_o, bus_cacheable_o, bus_early_ack_o, gateway_ok_o;
    logic fault_mem_manage_o, fault_secure_o, fault_align_o;
    logic [1:0]         req_size_i;
    logic [3:0]         bus_byte_en_o;
    logic [31:0]        req_addr_i, req_wdata_i, bus_addr_o, bus_wdata_o;
    logic [N-1:0][26:0] sau_base_i, sau_limit_i, mpus_base_i, mpus_limit_i;
    logic [N-1:0][26:0] mpun_base_i, mpun_limit_i;
    logic [N-1:0]       sau_en_i, sau_nsc_i, mpus_en_i, mpus_xn_i, mpus_ro_i;
    logic [N-1:0]       mpun_en_i, mpun_xn_i, mpun_ro_i;
    msa_memattr_t       mpus_attr_i [N];
    msa_memattr_t       mpun_attr_i [N];
    int                 num_errors, check_count;

    msa_checker #(.N(N), .IW(3)) dut (
        .clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_addr_i, .req_size_i,
        .req_write_i, .req_fetch_i, .req_gateway_i, .req_barrier_i,
        .req_nonsec_i, .req_wdata_i, .sau_enable_i, .sau_base_i, .sau_limit_i,
        .sau_en_i, .sau_nsc_i, .mpus_enable_i, .mpus_base_i, .mpus_limit_i,
        .mpus_en_i, .mpus_xn_i, .mpus_ro_i, .mpus_attr_i, .mpun_enable_i,
        .mpun_base_i, .mpun_limit_i, .mpun_en_i, .mpun_xn_i, .mpun_ro_i,
        .mpun_attr_i, .bus_valid_o, .bus_ready_i, .bus_done_i, .bus_addr_o,
        .bus_write_o, .bus_fetch_o, .bus_nonsec_o, .bus_device_o,
        .bus_shareable_o, .bus_cacheable_o, .bus_early_ack_o, .bus_byte_en_o,
        .bus_wdata_o, .fault_mem_manage_o, .fault_secure_o, .fault_align_o,
        .gateway_ok_o
    );

    msa_bus_responder bus_model (
        .clk_i, .rst_i, .bus_valid_i(bus_valid_o), .bus_device_i(bus_device_o),
        .slow_i(slow), .bus_ready_o(bus_ready_i), .bus_done_o(bus_done_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 50) begin
            chk(32'h0, 32'h1);
            end_of_test();
        end
    endtask

    // b: 0 attribution table, 1 secure bank, 2 non-secure bank
    task automatic setr(input int b, input int i, input logic [31:0] lo,
                        input logic [31:0] hi, input msa_memattr_t at);
        if (b == 0) begin
            sau_base_i[i]  = lo[31:5];
            sau_limit_i[i] = hi[31:5];
        end else if (b == 1) begin
            mpus_base_i[i]  = lo[31:5];
            mpus_limit_i[i] = hi[31:5];
            mpus_attr_i[i]  = at;
        end else begin
            mpun_base_i[i]  = lo[31:5];
            mpun_limit_i[i] = hi[31:5];
            mpun_attr_i[i]  = at;
        end
    endtask

    // exp: {bus valid, nonsec, device, early ack, manage, secure, align, gw}
    task automatic acc(input logic [31:0] a, input logic [1:0] sz,
                       input logic [4:0] ctl, input logic [7:0] exp,
                       input logic [3:0] be);
        logic [31:0] wm;
        logic [31:0] wv;
        int          n;
        @(posedge clk_i);
        req_addr_i <= a;
        req_size_i <= sz;
        {req_write_i, req_fetch_i, req_gateway_i, req_nonsec_i,
         req_barrier_i} <= ctl;
        req_valid_i <= 1'b1;
        @(negedge clk_i);
        first_ready = req_ready_o;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        tmo(n);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        @(negedge clk_i);
        chk({bus_valid_o, bus_nonsec_o, bus_device_o, bus_early_ack_o,
             fault_mem_manage_o, fault_secure_o, fault_align_o,
             gateway_ok_o} & (exp[7] ? 8'hFF : 8'h8F), exp);
        if (exp[7]) begin
            wm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
            wv = sz == 2'h2 ? WD : WD & (sz == 2'h1 ? 32'hFFFF : 32'hFF);
            chk({bus_write_o, bus_fetch_o, bus_byte_en_o},
                {ctl[4:3], be});
            if (ctl[4]) begin
                chk(bus_wdata_o & wm, (wv << (8 * a[1:0])) & wm);
            end
            chk({bus_shareable_o, bus_cacheable_o},
                exp[5] ? 2'b10 : 2'b01);
            n = 0;
            // address stands while the bus stalls
            while (bus_valid_o === 1'b1 && n < 50) begin
                chk(bus_addr_o, a);
                @(negedge clk_i);
                n++;
            end
            tmo(n);
        end else begin
            @(negedge clk_i);
            chk(bus_valid_o, 1'b0);
        end
    endtask

    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        num_errors = 0;
        check_count = 0;
        rst_i = 1'b1;
        slow = 1'b0;
        req_valid_i = 1'b0;
        req_addr_i = 32'h0;
        req_size_i = 2'h0;
        {req_write_i, req_fetch_i, req_gateway_i, req_nonsec_i} = 4'h0;
        req_barrier_i = 1'b0;
        req_wdata_i = WD;
        {sau_enable_i, mpus_enable_i, mpun_enable_i} = 3'b111;
        {sau_base_i, sau_limit_i, mpus_base_i, mpus_limit_i} = '0;
        {mpun_base_i, mpun_limit_i, mpus_ro_i, mpun_ro_i} = '0;
        for (int i = 0; i < N; i++) begin
            mpus_attr_i[i] = MSA_NORMAL;
            mpun_attr_i[i] = MSA_NORMAL;
        end
        setr(0, 0, 32'h1000_0000, 32'h1FFF_FFE0, MSA_NORMAL);
        setr(0, 1, 32'h0800_0000, 32'h08FF_FFE0, MSA_NORMAL);
        sau_en_i = 8'h03;
        sau_nsc_i = 8'h02;
        setr(1, 0, 32'h2000_0000, 32'h2000_0FE0, MSA_NORMAL);
        setr(1, 1, 32'h2000_1000, 32'h2000_1FE0, MSA_DEV_BAD);
        setr(1, 2, 32'h2000_2000, 32'h2000_2FE0, MSA_DEV_STRICT);
        setr(1, 3, 32'h1000_0000, 32'h1FFF_FFE0, MSA_DEV_BAD);
        mpus_en_i = 8'h0F;
        mpus_xn_i = 8'h09;
        setr(2, 0, 32'h1000_0000, 32'h1000_0FE0, MSA_DEV_STRICT);
        setr(2, 7, 32'h1000_0000, 32'h1000_00E0, MSA_DEV_EARLY);
        mpun_en_i = 8'h81;
        mpun_xn_i = 8'h00;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk({req_ready_o, bus_valid_o, fault_secure_o}, 3'b100);
        acc(32'h2000_0001, 2'h0, CW, 8'h80, 4'h2);
        acc(32'h2000_0002, 2'h1, CW, 8'h80, 4'hC);
        acc(32'h2000_0000, 2'h2, 5'h0, 8'h80, 4'hF);
        acc(32'h2000_0000, 2'h2, CF, 8'h08, 4'h0);
        acc(32'h2000_1000, 2'h2, 5'h0, 8'h08, 4'h0);
        acc(32'h2000_2000, 2'h2, CW, 8'hA0, 4'hF);
        acc(32'h2000_0004, 2'h2, 5'h0, 8'h80, 4'hF);
        chk(first_ready, 1'b1);
        slow = 1'b1;
        acc(32'h1000_0000, 2'h2, 5'h0, 8'hF0, 4'hF);
        acc(32'h1000_0100, 2'h2, CN, 8'hE0, 4'hF);
        chk(first_ready, 1'b0);
        acc(32'h1000_0100, 2'h2, 5'h0, 8'hE0, 4'hF);
        slow = 1'b0;
        acc(32'h2000_0000, 2'h2, CN, 8'h04, 4'h0);
        acc(32'h2000_0000, 2'h3, 5'h0, 8'h02, 4'h0);
        acc(32'h2000_0001, 2'h1, 5'h0, 8'h02, 4'h0);
        acc(32'h2000_2000, 2'h2, CW, 8'hA0, 4'hF);
        acc(32'h2000_0000, 2'h2, CB, 8'h00, 4'h0);
        chk(first_ready, 1'b0);
        @(posedge clk_i);
        sau_enable_i <= 1'b0;
        acc(32'h1000_0000, 2'h2, 5'h0, 8'h08, 4'h0);
        acc(32'h1000_0000, 2'h2, CN, 8'h04, 4'h0);
        @(posedge clk_i);
        {sau_enable_i, mpus_enable_i, mpun_enable_i} <= 3'b100;
        acc(32'h6000_0000, 2'h2, 5'h0, 8'h80, 4'hF);
        acc(32'h4000_0000, 2'h2, 5'h0, 8'hB0, 4'hF);
        acc(32'hF000_0000, 2'h2, 5'h0, 8'hB0, 4'hF);
        acc(32'hA000_0000, 2'h2, CF, 8'h08, 4'h0);
        acc(32'h0800_0000, 2'h2, CG | CN, 8'h81, 4'hF);
        acc(32'h0900_0000, 2'h2, CG | CN, 8'h04, 4'h0);
        acc(32'h1000_0000, 2'h2, CW, 8'hC0, 4'hF);
        end_of_test();
    end
endmodule
